//--- rtl/pad_path_config_regs.sv
// pad function and video/audio datapath configuration register bank
//
// Function
// R1: each pad function field is {direction, enable}: 00 functional input, 10 tri-state,
//     01 general-purpose output, 11 general-purpose input.
// R2: a pad carries its stored level only while in general-purpose output mode.
// R3: pad 8 uses bits 5-4 (function) and bit 7 (level) of offset 0x11, both r/w, reset 0.
// R4: pad 7 uses bits 1-0 (function) and bit 3 (level) of offset 0x11, both r/w.
// R5: pad 5 uses bits 1-0 of its register for function, resetting to functional input.
// R6: pad 5 uses bit 3 of the same register for its level, r/w, reset 0.
// R7: bit 5 of 0x12 set makes the active-video qualifier active low, clear active high.
// R8: bit 2 of 0x12 set selects 18-bit video, clear selects 24-bit video.
// R9: bit 0 of 0x12 enables the second audio channel taken from the second audio input.
// R10: in a repeater, in-band audio mode detection may override bit 0 of 0x12.
// R11: bit 3 of 0x12 set lets the second channel follow bit 0, clear forces it off.
// R12: bit 4 of 0x12 set regenerates repeater audio from audio pins, clear passes it through.
// R13: bit 1 of 0x12 set carries audio in the forward frame, clear in data islands.
// R14: the pad 7/8 register sits at 0x11 and resets to zero.
// R15: the datapath register sits at 0x12 and resets to zero.
// R16: read-only reserved bits read zero; writable reserved bit 6 of 0x12 only stores.
// R17: a register write reaches the controlled logic within a few clock cycles.
`timescale 1ns/1ns

module pad_path_config_regs (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             sys_rst,
    // register port
    input  wire logic                             reg_wr_en,
    input  wire logic                             reg_rd_en,
    input  wire logic [pad_path_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [pad_path_pkg::DATA_W-1:0]  reg_wdata,
    output logic      [pad_path_pkg::DATA_W-1:0]  reg_rdata,
    output logic                                  reg_rvalid,
    // pad controls, index 0 pad 5, 1 pad 7, 2 pad 8
    output logic      [pad_path_pkg::NUM_PADS-1:0] pad_out,
    output logic      [pad_path_pkg::NUM_PADS-1:0] pad_oe,
    output logic      [pad_path_pkg::NUM_PADS-1:0] pad_func_en,
    output logic      [pad_path_pkg::NUM_PADS-1:0] pad_gpio_in_en,
    output logic      [1:0]                        pad6_function_select,
    // repeater status from the audio receiver
    input  wire logic                             repeater_mode,
    input  wire logic                             inband_detect_valid,
    input  wire logic                             inband_second_audio,
    // datapath controls
    output logic                                  active_video_qualifier_polarity,
    output logic                                  reduced_colour_depth_select,
    output logic                                  audio_frame_transport,
    output logic                                  repeater_audio_regenerate,
    output logic                                  second_audio_enable
);
    import pad_path_pkg::*;

    // ==========================================================
    // register storage
    logic [7:0] pad56_q, pad56_d;
    logic [7:0] pad78_q, pad78_d;
    logic [7:0] path_q,  path_d;
    logic [7:0] rdata_d;
    logic       rvalid_d;

    // masked writes keep read-only reserved bits at zero
    always_comb begin
        pad56_d  = pad56_q;
        pad78_d  = pad78_q;
        path_d   = path_q;
        if (reg_wr_en) begin
            unique case (reg_addr)
                OFF_PAD5_PAD6: pad56_d = reg_wdata & WMASK_PAD5_PAD6;  // see R5 see R6
                OFF_PAD7_PAD8: pad78_d = reg_wdata & WMASK_PAD7_PAD8;  // see R3 see R4 see R14
                OFF_PATH_CTL:  path_d  = reg_wdata & WMASK_PATH_CTL;   // see R15 see R16
                default:       ;
            endcase
        end
    end

    // read answer one cycle after the strobe; unmapped offsets read zero
    always_comb begin
        rvalid_d = reg_rd_en;
        rdata_d  = reg_rdata;
        if (reg_rd_en) begin
            unique case (reg_addr)
                OFF_PAD5_PAD6: rdata_d = pad56_q;
                OFF_PAD7_PAD8: rdata_d = pad78_q;
                OFF_PATH_CTL:  rdata_d = path_q;   // see R16
                default:       rdata_d = RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pad56_q    <= RST_PAD5_PAD6;
            pad78_q    <= RST_PAD7_PAD8;  // see R14
            path_q     <= RST_PATH_CTL;   // see R15
            reg_rdata  <= RDATA_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            pad56_q    <= pad56_d;
            pad78_q    <= pad78_d;
            path_q     <= path_d;
            reg_rdata  <= rdata_d;
            reg_rvalid <= rvalid_d;
        end
    end

    // ==========================================================
    // pad decode
    pad_mode_t pad5_function_select, pad7_function_select, pad8_function_select;
    logic      pad5_drive_level, pad7_drive_level, pad8_drive_level;
    pad_mode_t pad_mode [NUM_PADS];
    logic      [NUM_PADS-1:0] pad_level;
    logic      [NUM_PADS-1:0] pad_out_d, pad_oe_d, pad_func_d, pad_gin_d;

    assign pad5_function_select = pad_mode_t'(pad56_q[LO_MODE_LSB +: 2]);  // see R5
    assign pad5_drive_level     = pad56_q[LO_LEVEL_BIT];                  // see R6
    assign pad7_function_select = pad_mode_t'(pad78_q[LO_MODE_LSB +: 2]);  // see R4
    assign pad7_drive_level     = pad78_q[LO_LEVEL_BIT];
    assign pad8_function_select = pad_mode_t'(pad78_q[HI_MODE_LSB +: 2]);  // see R3
    assign pad8_drive_level     = pad78_q[HI_LEVEL_BIT];
    assign pad_mode[0] = pad5_function_select;
    assign pad_mode[1] = pad7_function_select;
    assign pad_mode[2] = pad8_function_select;
    assign pad_level   = {pad8_drive_level, pad7_drive_level, pad5_drive_level};

    // level is gated to zero off output mode so a pad never shows a stale level
    always_comb begin
        for (int i = 0; i < NUM_PADS; i++) begin
            pad_oe_d[i]   = (pad_mode[i] == PAD_GPIO_OUT);           // see R1
            pad_out_d[i]  = pad_oe_d[i] & pad_level[i];              // see R2
            pad_func_d[i] = (pad_mode[i] == PAD_FUNC_IN);            // see R1
            pad_gin_d[i]  = (pad_mode[i] == PAD_GPIO_IN);            // see R1
        end
    end

    // ==========================================================
    // datapath decode
    logic second_d;

    // repeater detection wins only while the override lets channel two run at all
    always_comb begin
        second_d = 1'b0;                                             // see R11
        if (path_q[SECOND_OVERRIDE_BIT]) begin
            if (repeater_mode && inband_detect_valid) begin
                second_d = inband_second_audio;                      // see R10
            end else begin
                second_d = path_q[SECOND_AUDIO_EN_BIT];              // see R9
            end
        end
    end

    // one register stage: settings reach the datapath two edges after the write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pad_out                         <= '0;
            pad_oe                          <= '0;
            pad_func_en                     <= '1;
            pad_gpio_in_en                  <= '0;
            pad6_function_select            <= 2'h0;
            active_video_qualifier_polarity <= 1'b0;
            reduced_colour_depth_select     <= 1'b0;
            audio_frame_transport           <= 1'b0;
            repeater_audio_regenerate       <= 1'b0;
            second_audio_enable             <= 1'b0;
        end else begin
            pad_out                         <= pad_out_d;            // see R17
            pad_oe                          <= pad_oe_d;
            pad_func_en                     <= pad_func_d;
            pad_gpio_in_en                  <= pad_gin_d;
            pad6_function_select            <= pad56_q[HI_MODE_LSB +: 2];
            active_video_qualifier_polarity <= path_q[QUAL_POLARITY_BIT];  // see R7
            reduced_colour_depth_select     <= path_q[COLOUR_DEPTH_BIT];   // see R8
            audio_frame_transport           <= path_q[AUDIO_TRANSPORT_BIT];// see R13
            repeater_audio_regenerate       <= path_q[AUDIO_REGEN_BIT];    // see R12
            second_audio_enable             <= second_d;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_pad7_out_mode: assert property (  // see R4
        reg_wr_en && reg_addr == OFF_PAD7_PAD8 && reg_wdata[1:0] == 2'b01 && reg_wdata[3]
        |-> ##2 pad_oe[1] && pad_out[1])
        else $error("pad 7 not driving after output-mode write");
    a_pad8_fields: assert property (  // see R3
        reg_wr_en && reg_addr == OFF_PAD7_PAD8 && reg_wdata[5:4] == 2'b01
        |-> ##2 pad_oe[2] && pad_out[2] == $past(reg_wdata[7], 2))
        else $error("pad 8 mode or level wrong");
    a_pad_no_drive: assert property ((pad_out & ~pad_oe) == 3'h0)  // see R2
        else $error("pad level driven outside output mode");
    a_pad_one_mode: assert property (  // see R1
        $countones({pad_oe[0], pad_func_en[0], pad_gpio_in_en[0]}) <= 1)
        else $error("pad 5 decodes to two functions");
    a_pad5_tristate: assert property (  // see R5
        reg_wr_en && reg_addr == OFF_PAD5_PAD6 && reg_wdata[1:0] == 2'b10
        |-> ##2 !pad_oe[0] && !pad_func_en[0] && !pad_gpio_in_en[0])
        else $error("pad 5 not tri-stated");
    a_pad5_level: assert property (  // see R6
        reg_wr_en && reg_addr == OFF_PAD5_PAD6 && reg_wdata[1:0] == 2'b01
        |-> ##2 pad_out[0] == $past(reg_wdata[3], 2))
        else $error("pad 5 level wrong");
    a_path_settings: assert property (  // see R7
        reg_wr_en && reg_addr == OFF_PATH_CTL
        |-> ##2 active_video_qualifier_polarity == $past(reg_wdata[5], 2)
            && reduced_colour_depth_select == $past(reg_wdata[2], 2))  // see R8
        else $error("qualifier polarity or colour depth wrong");
    a_audio_modes: assert property (  // see R12
        reg_wr_en && reg_addr == OFF_PATH_CTL
        |-> ##2 repeater_audio_regenerate == $past(reg_wdata[4], 2)
            && audio_frame_transport == $past(reg_wdata[1], 2))  // see R13
        else $error("audio handling or transport wrong");
    a_second_forced: assert property (!path_q[3] |=> !second_audio_enable)  // see R11
        else $error("second audio channel on without override");
    a_second_follow: assert property (  // see R9
        path_q[3] && !repeater_mode |=> second_audio_enable == $past(path_q[0]))
        else $error("second audio channel ignores its enable");
    a_second_detect: assert property (  // see R10
        path_q[3] && repeater_mode && inband_detect_valid
        |=> second_audio_enable == $past(inband_second_audio))
        else $error("repeater detection not applied");
    a_rsvd_read: assert property (  // see R16
        reg_rd_en && reg_addr == OFF_PATH_CTL |=> reg_rvalid && !reg_rdata[7])
        else $error("reserved bit 7 reads nonzero");
    a_reset_zero: assert property (  // see R14 see R15
        $past(sys_rst) |-> pad78_q == 8'h00 && path_q == 8'h00)
        else $error("registers not zero after reset");

    c_pad_output:   cover property (pad_oe[1] && pad_out[1]);
    c_repeater_ovr: cover property (path_q[3] && repeater_mode && inband_detect_valid);
    c_path_read:    cover property (reg_rvalid && reg_rdata != 8'h00);

endmodule : pad_path_config_regs

//--- rtl/pad_path_pkg.sv
// constants, field layout and pad modes of the pad and datapath configuration bank
package pad_path_pkg;

    // ==========================================================
    // register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFF_PAD5_PAD6 = 8'h10;
    localparam logic [7:0] OFF_PAD7_PAD8 = 8'h11;
    localparam logic [7:0] OFF_PATH_CTL  = 8'h12;

    // ==========================================================
    // values after reset
    localparam logic [7:0] RST_PAD5_PAD6 = 8'h00;
    localparam logic [7:0] RST_PAD7_PAD8 = 8'h00;
    localparam logic [7:0] RST_PATH_CTL  = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ==========================================================
    // writable bits; read-only reserved bits are zero in the mask
    localparam logic [7:0] WMASK_PAD5_PAD6 = 8'h3b;
    localparam logic [7:0] WMASK_PAD7_PAD8 = 8'hbb;
    localparam logic [7:0] WMASK_PATH_CTL  = 8'h7f;

    // ==========================================================
    // field positions (pad registers: low pad in bits 1-0/3, high pad in 5-4, with level bit 7 at 0x11 only)
    localparam int unsigned LO_MODE_LSB  = 0;
    localparam int unsigned LO_LEVEL_BIT = 3;
    localparam int unsigned HI_MODE_LSB  = 4;
    localparam int unsigned HI_LEVEL_BIT = 7;

    localparam int unsigned SECOND_AUDIO_EN_BIT = 0;
    localparam int unsigned AUDIO_TRANSPORT_BIT = 1;
    localparam int unsigned COLOUR_DEPTH_BIT    = 2;
    localparam int unsigned SECOND_OVERRIDE_BIT = 3;
    localparam int unsigned AUDIO_REGEN_BIT     = 4;
    localparam int unsigned QUAL_POLARITY_BIT   = 5;

    // ==========================================================
    // pad function, coded {direction, enable}
    typedef enum logic [1:0] {
        PAD_FUNC_IN  = 2'b00,
        PAD_GPIO_OUT = 2'b01,
        PAD_TRISTATE = 2'b10,
        PAD_GPIO_IN  = 2'b11
    } pad_mode_t;

    localparam int unsigned NUM_PADS = 3;  // index 0 pad 5, 1 pad 7, 2 pad 8

endpackage : pad_path_pkg

//--- tb/pad_and_datapath_config_regs_tb.sv
// self-checking bench for the pad and datapath configuration bank
`timescale 1ns/1ns

module pad_and_datapath_config_regs_tb;
    import pad_path_pkg::*;

    // ==========================================================
    // signals and shadow copy of the bank
    logic              clk, sys_rst, wr_en, rd_en, rvalid;
    logic              rep, det_valid, det_second;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [2:0]        pout, poe, pfunc, pgin;
    logic [1:0]        pad6;
    logic              pol, depth, transport, regen, second;
    logic [7:0]        sh [3];
    logic [7:0]        wm [3] = '{8'h3b, 8'hbb, 8'h7f};  // writable bits of 0x10..0x12
    int                err_count = 0;
    int                n_compared = 0;
    int                cycles = 0;

    pad_path_config_regs DUT (
        .clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .pad_out(pout), .pad_oe(poe), .pad_func_en(pfunc), .pad_gpio_in_en(pgin),
        .pad6_function_select(pad6), .repeater_mode(rep),
        .inband_detect_valid(det_valid), .inband_second_audio(det_second),
        .active_video_qualifier_polarity(pol), .reduced_colour_depth_select(depth),
        .audio_frame_transport(transport), .repeater_audio_regenerate(regen),
        .second_audio_enable(second));

    // ==========================================================
    // clock and hang guard; ceiling is over ten times the expected run
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            $display("unexpected timeout at %0t", $time);
            wrap_up();
        end
    end

    // ==========================================================
    // expected outputs worked out from the shadow registers
    function automatic logic [18:0] exp_outs();
        logic [1:0] m [3];
        logic [2:0] lv, o, e, f, g;
        logic       sec;
        m[0] = sh[0][1:0];
        m[1] = sh[1][1:0];
        m[2] = sh[1][5:4];
        lv   = {sh[1][7], sh[1][3], sh[0][3]};
        for (int i = 0; i < 3; i++) begin
            e[i] = (m[i] == 2'b01);
            o[i] = e[i] & lv[i];
            f[i] = (m[i] == 2'b00);
            g[i] = (m[i] == 2'b11);
        end
        sec = sh[2][3] & ((rep & det_valid) ? det_second : sh[2][0]);
        return {o, e, f, g, sh[0][5:4], sh[2][5], sh[2][2], sh[2][1], sh[2][4], sec};
    endfunction : exp_outs

    // ==========================================================
    // compare tasks and register port tasks, all entered at a falling edge
    task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected read answer at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_outs(input logic [18:0] got, input logic [18:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected outputs at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_outs

    // the strobe drops for one edge so that a following call never re-raises it at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        if (a >= 8'h10 && a <= 8'h12) sh[a[1:0]] = d & wm[a[1:0]];
        @(negedge clk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] e;
        e     = (a >= 8'h10 && a <= 8'h12) ? sh[a[1:0]] : 8'h00;
        rd_en = 1'b1;
        addr  = a;
        @(negedge clk);
        rd_en = 1'b0;
        cmp_rd({rvalid, rdata}, {1'b1, e});
        @(negedge clk);
    endtask : rd_chk

    // outputs follow two edges after the write, which wr already spans; two spare edges for margin
    task automatic chk_outs();
        repeat (2) @(negedge clk);
        cmp_outs({pout, poe, pfunc, pgin, pad6, pol, depth, transport, regen, second},
                 exp_outs());
    endtask : chk_outs

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        {wr_en, rd_en, rep, det_valid, det_second} = 5'h00;
        addr  = 8'h00;
        wdata = 8'h00;
        sh    = '{default: 8'h00};
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        chk_outs();
        for (int a = 16; a < 20; a++) rd_chk(8'(a));
        // every function code on every pad, level high
        for (int m = 0; m < 4; m++) begin
            wr(8'h11, {2'b10, 2'(3 - m), 2'b10, 2'(m)});
            wr(8'h10, {2'b00, 2'(m), 2'b10, 2'(3 - m)});
            chk_outs();
            rd_chk(8'h11);
            rd_chk(8'h10);
        end
        wr(8'h11, 8'h11);
        chk_outs();
        // all ones everywhere, unmapped offset included
        for (int a = 16; a < 20; a++) begin
            wr(8'(a), 8'hff);
            rd_chk(8'(a));
        end
        chk_outs();
        // each datapath bit alone
        for (int b = 0; b < 8; b++) begin
            wr(8'h12, 8'h01 << b);
            chk_outs();
            rd_chk(8'h12);
        end
        // override bit, enable bit and repeater detection in every mix
        for (int c = 0; c < 32; c++) begin
            {rep, det_valid, det_second} = 3'(c);
            wr(8'h12, {4'h0, c[4], 2'b00, c[3]});
            chk_outs();
        end
        // write and read of one offset in one cycle returns the old byte
        wr_en = 1'b1;
        rd_en = 1'b1;
        addr  = 8'h11;
        wdata = 8'h00;
        @(negedge clk);
        {wr_en, rd_en} = 2'b00;
        cmp_rd({rvalid, rdata}, {1'b1, sh[1]});
        @(negedge clk);
        sh[1] = 8'h00;
        rd_chk(8'h11);
        // reset again in mid-run
        wr(8'h12, 8'h7f);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        sh = '{default: 8'h00};
        chk_outs();
        rd_chk(8'h12);
        wrap_up();
    end

endmodule : pad_and_datapath_config_regs_tb
